// ### include/gate_counter_pkg.sv
package gate_counter_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_GATE = 5'h04;
   localparam logic [4:0] OFF_CNTL = 5'h08;
   localparam logic [4:0] OFF_CNTH = 5'h0c;
   localparam logic [4:0] OFF_FLAG = 5'h10;
   // counter_control fields
   localparam int B_ON   = 0;
   localparam int B_SYNC = 2;
   localparam int B_PS   = 4;
   localparam int B_CS   = 6;
   // gate_control fields
   localparam int B_GSS  = 0;
   localparam int B_VAL  = 2;
   localparam int B_GO   = 3;
   localparam int B_SPM  = 4;
   localparam int B_GTM  = 5;
   localparam int B_POL  = 6;
   localparam int B_GE   = 7;
   // flag register fields
   localparam int B_ROLL = 0;
   localparam int B_GEV  = 1;
   // reset values and implemented-bit masks
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [7:0]  GATE_RST  = 8'h00;
   localparam logic [7:0]  CTRL_MASK = 8'hf5;
   localparam logic [7:0]  GATE_MASK = 8'hfb;
   localparam logic [15:0] CNT_MAX   = 16'hffff;
   // instruction clock is one aclk in four
   localparam logic [1:0]  INSTR_DIV_M1 = 2'h3;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;

   typedef enum logic [1:0] {CS_INSTR, CS_SYS, CS_EXT, CS_LFO} clk_src_e;
   typedef enum logic [1:0] {GS_PIN, GS_OVF, GS_CMP, GS_RSV} gate_src_e;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  gate;
      logic [15:0] count;
      logic        roll;
      logic        gev;
      logic [1:0]  div4;
      logic [2:0]  pre;
      logic        sync_tick;
      logic [1:0]  ext_s;
      logic [1:0]  lfo_s;
      logic [1:0]  pin_s;
      logic        ext_d;
      logic        lfo_d;
      logic        act_d;
      logic        tff;
      logic        g1_d;
      logic        started;
      logic        gval;
      logic        aw_got;
      logic        w_got;
      logic [4:0]  waddr;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [7:0]  rdata;
   } state_s;
endpackage

// ### hdl/gated_counter.sv
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
module gated_counter
   import gate_counter_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        external_count_input,
   input  wire logic        low_freq_internal_osc,
   input  wire logic        gate_input_pin,
   input  wire logic        byte_timer_overflow_pulse,
   input  wire logic        comparator_sync_output,
   output logic             rollover_flag,
   output logic             gate_event_flag
);
   import gate_counter_pkg::*;

   state_s     s;
   state_s     next_s;
   logic       on;
   logic       src_tick;
   logic       pre_tick;
   logic       inc_tick;
   logic [2:0] pmask;
   logic       raw;
   logic       act;
   logic       g1;
   logic       gv;
   logic       en;
   logic       do_wr;
   logic       wr_hit;
   logic       sp_done;
   logic [7:0] rd;
   logic       rd_ok;

   assign on = s.ctrl[B_ON];

   // outputs straight from the state flops
   assign s_axi_awready   = s.awready;
   assign s_axi_wready    = s.wready;
   assign s_axi_bvalid    = s.bvalid;
   assign s_axi_bresp     = s.bresp;
   assign s_axi_arready   = s.arready;
   assign s_axi_rvalid    = s.rvalid;
   assign s_axi_rresp     = s.rresp;
   assign s_axi_rdata     = {24'h000000, s.rdata};
   assign rollover_flag   = s.roll;
   assign gate_event_flag = s.gev;

   // read decode, gate level bit is live state
   always_comb
   begin
      rd    = 8'h00;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         OFF_CTRL: rd = s.ctrl & CTRL_MASK;
         OFF_GATE: rd = {s.gate[7:3], s.gval, s.gate[1:0]};
         OFF_CNTL: rd = s.count[7:0];
         OFF_CNTH: rd = s.count[15:8];
         OFF_FLAG: rd = {6'h00, s.gev, s.roll};
         default:  rd_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      next_s = s;
      // two-flop synchronisers for pins, then edge history
      next_s.ext_s = {s.ext_s[0], external_count_input};
      next_s.lfo_s = {s.lfo_s[0], low_freq_internal_osc};
      next_s.pin_s = {s.pin_s[0], gate_input_pin};
      next_s.ext_d = s.ext_s[1];
      next_s.lfo_d = s.lfo_s[1];
      next_s.div4  = s.div4 + 2'h1;

      // counter clock source as a one-cycle enable
      unique case (clk_src_e'(s.ctrl[B_CS+:2]))
         CS_INSTR: src_tick = (s.div4 == INSTR_DIV_M1);
         CS_SYS:   src_tick = 1'b1;
         CS_EXT:   src_tick = s.ext_s[1] & ~s.ext_d;
         CS_LFO:   src_tick = s.lfo_s[1] & ~s.lfo_d;
      endcase

      // prescaler: pass every 1, 2, 4 or 8 source ticks
      pmask    = {s.ctrl[B_PS+:2] == 2'h3, s.ctrl[B_PS+1], |s.ctrl[B_PS+:2]};
      pre_tick = src_tick && ((s.pre & pmask) == pmask);
      if (!on)
         next_s.pre = 3'h0;
      else if (src_tick)
         next_s.pre = s.pre + 3'h1;

      // extra retiming stage costs a cycle of latency
      next_s.sync_tick = pre_tick;
      inc_tick = s.ctrl[B_SYNC] ? pre_tick : s.sync_tick;

      // gate source and polarity
      unique case (gate_src_e'(s.gate[B_GSS+:2]))
         GS_PIN:  raw = s.pin_s[1];
         GS_OVF:  raw = byte_timer_overflow_pulse;
         GS_CMP:  raw = comparator_sync_output;
         GS_RSV:  raw = 1'b0;
      endcase
      if (s.gate[B_GSS+:2] == GS_RSV)
         act = 1'b0;
      else
         act = s.gate[B_POL] ? raw : ~raw;
      next_s.act_d = act;

      // toggle flop, held clear when off or mode disabled
      if (!on || !s.gate[B_GTM])
         next_s.tff = 1'b0;
      else if (act && !s.act_d)
         next_s.tff = ~s.tff;
      g1 = s.gate[B_GTM] ? s.tff : act;
      next_s.g1_d = g1;

      // single pulse: arm, see leading edge, finish on trailing edge
      sp_done = s.gate[B_SPM] && s.gate[B_GO] && s.started && !g1 && s.g1_d;
      if (!s.gate[B_SPM] || !s.gate[B_GO])
         next_s.started = 1'b0;
      else if (g1 && !s.g1_d)
         next_s.started = 1'b1;
      if (sp_done)
      begin
         next_s.started    = 1'b0;
         next_s.gate[B_GO] = 1'b0;
      end
      gv = s.gate[B_SPM] ? (g1 && s.started && s.gate[B_GO]) : g1;
      next_s.gval = gv;

      // count enable, gate only matters while on
      en = on && inc_tick && (!s.gate[B_GE] || s.gval);
      if (en)
         next_s.count = s.count + 16'h0001;

      // write channel capture, either order
      if (s_axi_awvalid && s.awready)
      begin
         next_s.aw_got = 1'b1;
         next_s.waddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready)
      begin
         next_s.w_got  = 1'b1;
         next_s.wdata  = s_axi_wdata[7:0];
         next_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready)
         next_s.bvalid = 1'b0;

      // perform the write once both halves are held
      do_wr  = s.aw_got && s.w_got && !s.bvalid;
      wr_hit = do_wr && s.wstrb0;
      if (do_wr)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OK;
         unique case (s.waddr)
            OFF_CTRL: if (wr_hit) next_s.ctrl = s.wdata & CTRL_MASK;
            OFF_GATE: if (wr_hit) next_s.gate = s.wdata & GATE_MASK;
            OFF_CNTL: if (wr_hit) next_s.count[7:0] = s.wdata;
            OFF_CNTH: if (wr_hit) next_s.count[15:8] = s.wdata;
            OFF_FLAG: if (wr_hit)
            begin
               // write one to clear; new events below still win
               next_s.roll = s.roll & ~s.wdata[B_ROLL];
               next_s.gev  = s.gev & ~s.wdata[B_GEV];
            end
            default:  next_s.bresp = RESP_ERR;
         endcase
      end

      // hardware set beats software clear
      if (en && s.count == CNT_MAX)
         next_s.roll = 1'b1;
      if (s.gval && !gv)
         next_s.gev = 1'b1;

      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready  = !next_s.w_got && !next_s.bvalid;

      // read: one outstanding, answer the cycle after the address
      if (s_axi_arvalid && s.arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = rd;
         next_s.rresp  = rd_ok ? RESP_OK : RESP_ERR;
      end
      else if (s.rvalid && s_axi_rready)
         next_s.rvalid = 1'b0;
      next_s.arready = !next_s.rvalid;
   end

   // single reset domain; power-on values only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s      <= '0;
         s.ctrl <= CTRL_RST;
         s.gate <= GATE_RST;
      end
      else
         s <= next_s;
   end

   sequence sp_armed;
      s.gate[B_SPM] && s.gate[B_GO] && s.started;
   endsequence

   sequence trail_edge;
      s.g1_d && !g1;
   endsequence

   a_wrap_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      en && s.count == CNT_MAX && !do_wr |=> s.count == 16'h0000 && s.roll)
      else $error("count did not wrap with rollover flag");

   a_off_clears_tff: assert property (@(posedge aclk) disable iff (!aresetn)
      !on |=> !s.tff)
      else $error("toggle flop not cleared while off");

   a_gtm_clear_tff: assert property (@(posedge aclk) disable iff (!aresetn)
      !s.gate[B_GTM] ##1 !s.gate[B_GTM] |-> !s.tff)
      else $error("toggle flop set with toggle mode off");

   a_gate_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      on && s.gate[B_GE] && !s.gval && !do_wr |=> $stable(s.count))
      else $error("count moved while gate inactive");

   a_gate_event: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(s.gval) |-> s.gev)
      else $error("gate falling edge did not set event flag");

   a_pulse_done: assert property (@(posedge aclk) disable iff (!aresetn)
      sp_armed ##0 trail_edge ##0 !do_wr |=> !s.gate[B_GO] ##1 !s.started)
      else $error("go not cleared on trailing edge");

   a_rsv_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      s.gate[B_GSS+:2] == GS_RSV |-> !act ##1 !s.act_d)
      else $error("reserved gate source not inactive");

   // system clock source at divide by 8: a tick is never followed by another at once
   a_div8_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
      on && s.ctrl[7:4] == 4'h7 && pre_tick ##1 s.ctrl[7:4] == 4'h7 |-> !pre_tick)
      else $error("prescale by 8 ticked early");

   a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      !s.ctrl[B_SYNC] && pre_tick ##1 !s.ctrl[B_SYNC] |-> inc_tick)
      else $error("retimed count tick missing");

   a_sys_clock: assert property (@(posedge aclk) disable iff (!aresetn)
      on && s.ctrl[7:4] == 4'h4 && s.ctrl[B_SYNC] && !s.gate[B_GE] && !do_wr
      |=> s.count == $past(s.count) + 16'h0001)
      else $error("system clock source did not count every cycle");

   a_ctrl_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      s.ctrl[3] == 1'b0 && s.ctrl[1] == 1'b0)
      else $error("unimplemented control bit stored");

   a_instr_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      on && s.ctrl[7:4] == 4'h0 && s.ctrl[B_SYNC] && inc_tick && !do_wr |=> !inc_tick)
      else $error("quarter clock ticked on consecutive cycles");

   a_off_no_count: assert property (@(posedge aclk) disable iff (!aresetn)
      !on && !do_wr |=> $stable(s.count))
      else $error("count moved while counter off");

   a_gate_free_run: assert property (@(posedge aclk) disable iff (!aresetn)
      on && !s.gate[B_GE] && inc_tick && !do_wr |=> s.count == $past(s.count) + 16'h0001)
      else $error("count did not advance with gate control off");

   // comparator level reaches the status bit one cycle later, polarity applied
   a_cmp_source: assert property (@(posedge aclk) disable iff (!aresetn)
      s.gate[B_GSS+:2] == GS_CMP && s.gate[5:4] == 2'h0 ##1 $stable(s.gate)
      |-> s.gval == (s.gate[B_POL] ~^ $past(comparator_sync_output)))
      else $error("comparator gate level wrong");

   a_ovf_source: assert property (@(posedge aclk) disable iff (!aresetn)
      s.gate[B_GSS+:2] == GS_OVF && s.gate[5:4] == 2'h0 ##1 $stable(s.gate)
      |-> s.gval == (s.gate[B_POL] ~^ $past(byte_timer_overflow_pulse)))
      else $error("overflow gate level wrong");

   // pin goes through two sync flops before the registered status bit
   a_pin_source: assert property (@(posedge aclk) disable iff (!aresetn)
      s.gate[B_GSS+:2] == GS_PIN && s.gate[5:4] == 2'h0 ##1 $stable(s.gate)
      |-> s.gval == (s.gate[B_POL] ~^ $past(gate_input_pin, 3)))
      else $error("pin gate level wrong");

   a_toggle_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      on && s.gate[B_GTM] && act && !s.act_d |=> s.tff == !$past(s.tff))
      else $error("toggle flop missed a rising gate edge");

   a_go_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
      s.gate[B_SPM] && !s.gate[B_GO] |=> !s.gval)
      else $error("gate open without armed single pulse");

   a_go_hw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      !s.gate[B_GO] && !do_wr |=> !s.gate[B_GO])
      else $error("go bit set without a write");

   a_roll_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      s.roll && !(do_wr && s.waddr == OFF_FLAG) |=> s.roll)
      else $error("rollover flag dropped without a clear");

   a_gev_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      s.gev && !(do_wr && s.waddr == OFF_FLAG) |=> s.gev)
      else $error("gate event flag dropped without a clear");

   a_read_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CTRL
      |=> s_axi_rdata[3] == 1'b0 && s_axi_rdata[1] == 1'b0)
      else $error("unimplemented control bit read back");
endmodule

// ### dv/signal_sources.sv
`timescale 1ns/10ps
// stand-in for count pin, oscillator, gate pin and on-chip gate sources
module signal_sources (
   input  wire logic aclk,
   input  wire logic ext_run,
   input  wire logic gate_lvl,
   input  wire logic ovf_run,
   input  wire logic cmp_lvl,
   output logic      external_count_input,
   output logic      low_freq_internal_osc,
   output logic      gate_input_pin,
   output logic      byte_timer_overflow_pulse,
   output logic      comparator_sync_output
);
   logic [3:0] phase = 4'h0;

   // free phase counter sets the count pin, oscillator and overflow pulse rates
   always_ff @(posedge aclk)
   begin
      phase <= phase + 4'h1;
   end

   // count pin rises every 8 cycles, parked low when idle
   assign external_count_input      = ext_run & phase[2];
   assign low_freq_internal_osc     = phase[3];
   assign gate_input_pin            = gate_lvl;
   assign byte_timer_overflow_pulse = ovf_run & (phase[2:0] == 3'h0);
   assign comparator_sync_output    = cmp_lvl;
endmodule

// ### dv/gated_counter_tb_top.sv
`timescale 1ns/10ps
module gated_counter_tb_top;
   import gate_counter_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [4:0]  s_axi_awaddr = 5'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [4:0]  s_axi_araddr = 5'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic        gate_lvl = 1'b0;
   logic        ext_pin;
   logic        lfo;
   logic        gpin;
   logic        ovf;
   logic        cmp;
   logic        rollover_flag;
   logic        gate_event_flag;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   // ctrl, gate, expected count over an 800-cycle window
   logic [31:0] tbl [15] = '{
      32'h4500_0320, 32'h5500_0190, 32'h6500_00c8, 32'h7500_0064,
      32'h0500_00c8, 32'h8100_0064, 32'hc100_0032, 32'h4100_0320,
      32'h45c0_0000, 32'h4580_0320, 32'h45c3_0000, 32'h4583_0000,
      32'h45c1_0064, 32'h45c2_0320, 32'h4540_0320};

   always #5 aclk = !aclk;

   gated_counter DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .external_count_input(ext_pin), .low_freq_internal_osc(lfo),
      .gate_input_pin(gpin), .byte_timer_overflow_pulse(ovf),
      .comparator_sync_output(cmp), .rollover_flag(rollover_flag),
      .gate_event_flag(gate_event_flag));

   signal_sources src (.aclk(aclk), .ext_run(aresetn), .gate_lvl(gate_lvl),
      .ovf_run(aresetn), .cmp_lvl(aresetn), .external_count_input(ext_pin),
      .low_freq_internal_osc(lfo), .gate_input_pin(gpin),
      .byte_timer_overflow_pulse(ovf), .comparator_sync_output(cmp));

   task automatic stop_test;
      if (num_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard, well above the length of the whole sequence
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         num_errors++;
         stop_test();
      end
   end

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // count is sampled asynchronously to bus latency, so allow a small window
   function automatic logic [15:0] near(input logic [15:0] c, input int e);
      return (c + 6 >= e && c <= e + (e != 0 ? 6 : 0)) ? c : e[15:0];
   endfunction

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic w(input logic [4:0] a, input logic [7:0] d);
      logic [1:0] r;
      wr(a, d, r);
   endtask

   task automatic cnt_rd(output logic [15:0] c);
      logic [7:0] lo;
      logic [7:0] hi;
      logic [1:0] r;
      rd(OFF_CNTL, lo, r);
      rd(OFF_CNTH, hi, r);
      c = {hi, lo};
   endtask

   task automatic pulse(input int n);
      @(posedge aclk);
      gate_lvl <= 1'b1;
      repeat (n) @(posedge aclk);
      gate_lvl <= 1'b0;
      repeat (10) @(posedge aclk);
   endtask

   // one counting window with a given setup, counter stopped before reading
   task automatic run(input logic [31:0] t);
      logic [15:0] c;
      w(OFF_CTRL, 8'h00);
      w(OFF_CNTL, 8'h00);
      w(OFF_CNTH, 8'h00);
      w(OFF_GATE, t[23:16]);
      w(OFF_CTRL, t[31:24]);
      repeat (800) @(posedge aclk);
      w(OFF_CTRL, 8'h00);
      cnt_rd(c);
      chk("count", c, near(c, t[15:0]));
   endtask

   initial
   begin
      logic [7:0]  d;
      logic [1:0]  r;
      logic [15:0] c;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(OFF_CTRL, d, r);
      chk("ctrl reset", d, CTRL_RST);
      rd(OFF_GATE, d, r);
      chk("gate reset", d & 8'hfb, GATE_RST);
      cnt_rd(c);
      chk("count reset", c, 16'h0000);
      w(OFF_CTRL, 8'hfe);
      rd(OFF_CTRL, d, r);
      chk("ctrl unused", d, 8'hf4);
      w(OFF_CTRL, 8'h00);
      w(OFF_CNTL, 8'h34);
      w(OFF_CNTH, 8'h12);
      cnt_rd(c);
      chk("count rw", c, 16'h1234);
      wr(5'h14, 8'h5a, r);
      chk("unmapped wresp", r, RESP_ERR);
      rd(5'h18, d, r);
      chk("unmapped rresp", r, RESP_ERR);
      chk("unmapped data", d, 8'h00);
      for (int i = 0; i < 15; i++) run(tbl[i]);
      // start just below the top so the wrap comes quickly
      w(OFF_CNTL, 8'hfd);
      w(OFF_CNTH, 8'hff);
      w(OFF_CTRL, 8'h45);
      repeat (10) @(posedge aclk);
      w(OFF_CTRL, 8'h00);
      chk("rollover pin", rollover_flag, 1'b1);
      cnt_rd(c);
      chk("wrapped", c < 16'h0020, 1'b1);
      rd(OFF_FLAG, d, r);
      chk("rollover reg", d[0], 1'b1);
      w(OFF_FLAG, 8'h03);
      chk("rollover clr", rollover_flag, 1'b0);
      w(OFF_GATE, 8'h40);
      @(posedge aclk);
      gate_lvl <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(OFF_GATE, d, r);
      chk("gate level hi", d[2], 1'b1);
      // drop the gate on its own edge, one assignment per time step
      @(posedge aclk);
      gate_lvl <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(OFF_GATE, d, r);
      chk("gate level lo", d[2], 1'b0);
      chk("gate event", gate_event_flag, 1'b1);
      // one rising edge flips the toggle flop, clearing the mode resets it
      // counter must run, the flop is held clear while off
      w(OFF_CTRL, 8'h45);
      w(OFF_GATE, 8'h60);
      pulse(5);
      rd(OFF_GATE, d, r);
      chk("toggled", d[2], 1'b1);
      // re-enabling toggle mode with gate low shows whether the flop was cleared
      w(OFF_GATE, 8'h40);
      w(OFF_GATE, 8'h60);
      rd(OFF_GATE, d, r);
      chk("toggle clr", d[2], 1'b0);
      pulse(5);
      w(OFF_CTRL, 8'h00);
      rd(OFF_GATE, d, r);
      chk("off clears toggle", d[2], 1'b0);
      // single pulse: only the first armed pulse counts
      w(OFF_CNTL, 8'h00);
      w(OFF_CNTH, 8'h00);
      w(OFF_GATE, 8'hd0);
      w(OFF_GATE, 8'hd8);
      w(OFF_CTRL, 8'h45);
      rd(OFF_GATE, d, r);
      chk("go armed", d[3], 1'b1);
      pulse(40);
      rd(OFF_GATE, d, r);
      chk("go done", d[3], 1'b0);
      pulse(40);
      w(OFF_CTRL, 8'h00);
      cnt_rd(c);
      chk("pulse count", c, near(c, 40));
      stop_test();
   end
endmodule
